// *** design/sdc_pkg.sv ***
// Shared constants and types for the synchronous DRAM command block
package sdc_pkg;

  // ==========================================================
  // Pin widths and bank layout
  localparam int ADDR_W = 13;
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ALL_BANK_BIT = 10;

  // ==========================================================
  // Burst length codes of the mode field, bits 2 to 0
  localparam logic [2:0] BL_ONE = 3'h0;
  localparam logic [2:0] BL_TWO = 3'h1;
  localparam logic [2:0] BL_FOUR = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;

  // ==========================================================
  // Latencies in clock cycles
  localparam int MASK_OUTPUT_OFF_LATENCY = 2;
  localparam int MASK_WRITE_LATENCY = 0;
  localparam int CAS_LAT_MAX = 3;
  localparam logic [2:0] CAS_LAT_DEFAULT = 3'h3;

  // ==========================================================
  // Write buffer
  localparam int WBUF_DEPTH = 32;

  // ==========================================================
  // Reset values
  localparam logic [BANKS-1:0] BANKS_CLOSED = 4'h0;

  // Decoded command on one sampled edge
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACTIVATE,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_BURST_STOP
  } sdc_cmd_t;

  // Power state
  typedef enum logic {
    PWR_RUN,
    PWR_DOWN
  } sdc_pwr_t;

endpackage

// *** design/sdc_burst_col.sv ***
// Column sequencer: column of one burst beat from start column and beat count
`timescale 1ns/1ns
`default_nettype none

module sdc_burst_col #(
  parameter int COL_W = 6
) (
  // Burst description
  input wire logic [COL_W-1:0] i_start,
  input wire logic [COL_W-1:0] i_cnt,
  input wire logic [2:0] i_burst_length_field,
  input wire logic i_interleave,
  // Result
  output logic [COL_W-1:0] o_col,
  output logic o_last
);

  // ==========================================================
  // Wrap mask from the length code
  logic [COL_W-1:0] wrap_mask;
  logic full_page;
  logic [COL_W-1:0] seq_col;
  logic [COL_W-1:0] ilv_col;

  // Reserved codes behave as single beats
  always_comb begin
    full_page = (i_burst_length_field == sdc_pkg::BL_FULL);
    unique case (i_burst_length_field)
      sdc_pkg::BL_TWO: wrap_mask = COL_W'(1);
      sdc_pkg::BL_FOUR: wrap_mask = COL_W'(3);
      sdc_pkg::BL_EIGHT: wrap_mask = COL_W'(7);
      sdc_pkg::BL_FULL: wrap_mask = '1;
      default: wrap_mask = '0;
    endcase
  end

  // ==========================================================
  // Address sequence, wrapping inside the block
  always_comb begin
    seq_col = COL_W'(i_start + i_cnt);
    ilv_col = i_start ^ i_cnt;
    // Full page ignores the interleave bit: only sequential exists
    if (i_interleave && !full_page) begin
      o_col = (i_start & ~wrap_mask) | (ilv_col & wrap_mask);
    end else begin
      o_col = (i_start & ~wrap_mask) | (seq_col & wrap_mask);
    end
    // Full page never runs out by itself
    o_last = !full_page && ((i_cnt & wrap_mask) == wrap_mask);
  end

endmodule

`default_nettype wire

// *** design/sdc_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module sdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);

  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [PTR_W:0] count;
  } sdc_fifo_state_t;

  sdc_fifo_state_t s;
  sdc_fifo_state_t next_s;
  logic [WIDTH-1:0] store [DEPTH];
  logic push;
  logic pop;

  // ==========================================================
  // Honest full and empty flags
  assign o_ready = (s.count < (PTR_W+1)'(DEPTH));
  assign o_valid = (s.count != '0);
  assign o_data = store[s.rptr];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Pointer and level update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wptr = (s.wptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(s.wptr + 1'b1);
    end
    if (pop) begin
      next_s.rptr = (s.rptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(s.rptr + 1'b1);
    end
    next_s.count = (PTR_W+1)'(s.count + push - pop);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Storage needs no reset: nothing reads an empty slot
  always_ff @(posedge i_clk) begin
    if (push) begin
      store[s.wptr] <= i_data;
    end
  end

endmodule

`default_nettype wire

// *** design/sdc_sdram_core.sv ***
// Command decoder, bank state, burst engine, mask timing and power-down of the DRAM
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - New read or write cuts running burst
// - Precharge ends burst and closes bank
// - Burst stop ends burst, row stays open
// - Burst stop drops remaining write data
// - Write data before stop is stored
// - Activate opens addressed row in bank
// - Write enable high reads, low writes
// - Burst length 1,2,4,8,page within block
// - Columns after first generated internally
// - Full page only with sequential type
// - Full page runs until terminated
// - New burst any cycle, full length
// - Interleaved access between open banks
// - Mask high disables reads two clocks later
// - Mask blocks write data same clock
// - Clock enable low with all banks idle enters power-down
// - Clock enable high exits, one clock delay
// - Length field bits 2:0, all-ones page
// - All-bank flag closes every bank
module sdc_sdram_core #(
  parameter int DQ_W = 8,
  parameter int ROW_W = 4,
  parameter int COL_W = 6,
  parameter int WBUF_DEPTH = sdc_pkg::WBUF_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Command pins
  input wire logic i_cke,
  input wire logic i_row_strobe_n,
  input wire logic i_col_strobe_n,
  input wire logic i_write_en_n,
  input wire logic [sdc_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_bank_select_low,
  input wire logic i_bank_select_high,
  input wire logic i_mask,
  // Data pins, split into in, out and enable
  input wire logic [DQ_W-1:0] i_dq,
  output logic [DQ_W-1:0] o_dq,
  output logic o_dq_oe,
  // Mode settings
  input wire logic [2:0] i_burst_length_field,
  input wire logic i_burst_type,
  input wire logic [2:0] i_cas_latency,
  // Status
  output logic o_power_down,
  output logic [sdc_pkg::BANKS-1:0] o_bank_open,
  output logic o_burst_active,
  output logic o_write_ready
);

  localparam int MEM_AW = sdc_pkg::BANK_W + ROW_W + COL_W;
  localparam int WB_W = MEM_AW + DQ_W;
  localparam int LAT = sdc_pkg::CAS_LAT_MAX;
  // Array keeps only ROW_W row bits per bank to stay small in simulation;
  // widen ROW_W for a deeper model, nothing else depends on it

  // All block state in one word, so reset and hold are a single assignment;
  // the read pipeline keeps one slot per cycle of the longest latency
  typedef struct packed {
    logic cke_prev;
    sdc_pkg::sdc_pwr_t pwr;
    logic [sdc_pkg::BANKS-1:0] open;
    logic [sdc_pkg::BANKS-1:0][ROW_W-1:0] row;
    logic bur_act;
    logic bur_wr;
    logic [sdc_pkg::BANK_W-1:0] bur_bank;
    logic [COL_W-1:0] bur_start;
    logic [COL_W-1:0] bur_cnt;
    logic [sdc_pkg::MASK_OUTPUT_OFF_LATENCY-1:0] mask_q;
    logic [LAT-1:0] rd_vld;
    logic [LAT-1:0][DQ_W-1:0] rd_dat;
    logic [DQ_W-1:0] dq_out;
    logic dq_oe;
  } sdc_core_state_t;

  sdc_core_state_t s;
  sdc_core_state_t next_s;

  // ==========================================================
  // Command sampling and decode
  logic cmd_en;
  sdc_pkg::sdc_cmd_t cmd;
  logic [sdc_pkg::BANK_W-1:0] cmd_bank;

  // Inputs count only on edges where the clock stays enabled
  assign cmd_en = i_cke && s.cke_prev && (s.pwr == sdc_pkg::PWR_RUN);
  // Bank select pair, low pin as the upper index bit
  // Low=0 with high=1 is bank 1, as in the precharge bank table
  assign cmd_bank = {i_bank_select_low, i_bank_select_high};

  // Strobe decode; write enable picks the column direction
  always_comb begin
    cmd = sdc_pkg::CMD_NOP;
    if (cmd_en) begin
      unique case ({i_row_strobe_n, i_col_strobe_n, i_write_en_n})
        3'h3: cmd = sdc_pkg::CMD_ACTIVATE;
        3'h5: cmd = sdc_pkg::CMD_READ;
        3'h4: cmd = sdc_pkg::CMD_WRITE;
        3'h2: cmd = sdc_pkg::CMD_PRECHARGE;
        3'h6: cmd = sdc_pkg::CMD_BURST_STOP;
        default: cmd = sdc_pkg::CMD_NOP;
      endcase
    end
  end

  // ==========================================================
  // Beat selection: a new column command or the running burst
  logic new_burst;
  logic beat;
  logic beat_wr;
  logic [sdc_pkg::BANK_W-1:0] beat_bank;
  logic [COL_W-1:0] gen_start;
  logic [COL_W-1:0] gen_cnt;
  logic [COL_W-1:0] beat_col;
  logic beat_last;
  logic bur_killed;
  logic [MEM_AW-1:0] beat_addr;

  // Column commands to a closed bank are dropped; the controller honours the
  // row-to-column delay itself, the array has no timing to check it against
  assign new_burst = ((cmd == sdc_pkg::CMD_READ) || (cmd == sdc_pkg::CMD_WRITE))
    && s.open[cmd_bank];

  // Precharge of the burst's bank or all banks kills it
  always_comb begin
    bur_killed = 1'b0;
    if (cmd == sdc_pkg::CMD_BURST_STOP) begin
      bur_killed = 1'b1;
    end else if (cmd == sdc_pkg::CMD_PRECHARGE) begin
      bur_killed = i_addr[sdc_pkg::ALL_BANK_BIT] || (cmd_bank == s.bur_bank);
    end
  end

  // A new command overrides the old burst at once
  assign beat = new_burst || (s.bur_act && cmd_en && !bur_killed);
  assign beat_wr = new_burst ? (cmd == sdc_pkg::CMD_WRITE) : s.bur_wr;
  assign beat_bank = new_burst ? cmd_bank : s.bur_bank;
  assign gen_start = new_burst ? i_addr[COL_W-1:0] : s.bur_start;
  assign gen_cnt = new_burst ? '0 : s.bur_cnt;
  assign beat_addr = {beat_bank, s.row[beat_bank], beat_col};

  // First column from the command, the rest generated here
  sdc_burst_col #(
    .COL_W(COL_W)
  ) u_col (
    .i_start(gen_start),
    .i_cnt(gen_cnt),
    .i_burst_length_field(i_burst_length_field),
    .i_interleave(i_burst_type),
    .o_col(beat_col),
    .o_last(beat_last)
  );

  // ==========================================================
  // Memory array and write buffer
  logic [DQ_W-1:0] mem [2**MEM_AW];
  logic wb_push;
  logic wb_ready;
  logic wb_valid;
  logic wb_drain;
  logic [WB_W-1:0] wb_data;

  // Mask blocks the same-edge write beat stopped bursts push nothing
  assign wb_push = beat && beat_wr && !i_mask;
  // Read beats own the array port; the buffer drain waits meanwhile
  // A long read burst can therefore hold queued words back for a while
  assign wb_drain = !(beat && !beat_wr);

  sdc_fifo #(
    .WIDTH(WB_W),
    .DEPTH(WBUF_DEPTH)
  ) u_wbuf (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_valid(wb_push),
    .i_data({beat_addr, i_dq}),
    .o_ready(wb_ready),
    .o_valid(wb_valid),
    .o_data(wb_data),
    .i_ready(wb_drain)
  );

  // Buffered write lands in the array; a read of a still queued word is stale
  always_ff @(posedge i_clk) begin
    if (wb_valid && wb_drain) begin
      mem[wb_data[WB_W-1:DQ_W]] <= wb_data[DQ_W-1:0];
    end
  end

  // ==========================================================
  // Read latency slot: data leaves after the programmed CAS latency
  // Slot index is latency minus one: slot zero drives the pins on the
  // following edge, so the host sees the word exactly latency edges later
  logic [1:0] lat_slot;

  // Reserved latency codes fall back to the longest
  always_comb begin
    unique case (i_cas_latency)
      3'h1: lat_slot = 2'h0;
      3'h2: lat_slot = 2'h1;
      default: lat_slot = 2'h2;
    endcase
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.cke_prev = i_cke;
    // Power-down only with all banks idle; otherwise the clock is just held
    if (!i_cke && s.open == sdc_pkg::BANKS_CLOSED && !s.bur_act) begin
      next_s.pwr = sdc_pkg::PWR_DOWN;
    end else if (i_cke) begin
      next_s.pwr = sdc_pkg::PWR_RUN;
    end
    if (cmd_en) begin
      // Mask pipeline for output disable
      next_s.mask_q = {s.mask_q[0], i_mask};
      next_s.rd_vld = {1'b0, s.rd_vld[LAT-1:1]};
      next_s.rd_dat = {{DQ_W{1'b0}}, s.rd_dat[LAT-1:1]};
      // A write takes the bus back from any read still in flight
      if (new_burst && beat_wr) begin
        next_s.rd_vld = '0;
      end
      if (beat && !beat_wr) begin
        next_s.rd_vld[lat_slot] = 1'b1;
        next_s.rd_dat[lat_slot] = mem[beat_addr];
      end
      // Masking gates only the enable; the word still walks the pipeline so a
      // later unmasked beat is not shifted out of place
      // Output drive taken from slot zero, gated by the delayed mask
      next_s.dq_out = next_s.rd_dat[0];
      next_s.dq_oe = next_s.rd_vld[0] && !next_s.mask_q[1];
      // Bank open and close
      unique case (cmd)
        sdc_pkg::CMD_ACTIVATE: begin
          if (!s.open[cmd_bank]) begin
            next_s.open[cmd_bank] = 1'b1;
            next_s.row[cmd_bank] = i_addr[ROW_W-1:0];
          end
        end
        sdc_pkg::CMD_PRECHARGE: begin
          if (i_addr[sdc_pkg::ALL_BANK_BIT]) begin
            next_s.open = sdc_pkg::BANKS_CLOSED;
          end else begin
            next_s.open[cmd_bank] = 1'b0;
          end
        end
        default: begin
        end
      endcase
      // Burst bookkeeping; stop leaves the row open
      if (new_burst) begin
        next_s.bur_wr = beat_wr;
        next_s.bur_bank = cmd_bank;
        next_s.bur_start = i_addr[COL_W-1:0];
      end
      if (beat) begin
        next_s.bur_act = !beat_last;
        next_s.bur_cnt = COL_W'(gen_cnt + 1'b1);
      end else if (bur_killed) begin
        next_s.bur_act = 1'b0;
      end
    end
  end

  // ==========================================================
  // State register
  // Synchronous reset only; after release the clock enable must be seen
  // high on two edges before the first command is taken
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  // Status comes straight from registers, so the host may sample it on any
  // edge without a combinational path back to its own command pins
  assign o_dq = s.dq_out;
  assign o_dq_oe = s.dq_oe;
  assign o_power_down = (s.pwr == sdc_pkg::PWR_DOWN);
  assign o_bank_open = s.open;
  assign o_burst_active = s.bur_act;
  // Full buffer loses write beats; the host must watch this
  assign o_write_ready = wb_ready;

endmodule

`default_nettype wire

// *** testbench/sdc_sdram_props.sv ***
// Concurrent checks on the DRAM command block ports
`timescale 1ns/1ns
`default_nettype none

module sdc_sdram_props (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Command pins
  input wire logic i_cke,
  input wire logic i_row_strobe_n,
  input wire logic i_col_strobe_n,
  input wire logic i_write_en_n,
  input wire logic [sdc_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_bank_select_low,
  input wire logic i_bank_select_high,
  input wire logic i_mask,
  input wire logic [2:0] i_burst_length_field,
  // Status
  input wire logic o_dq_oe,
  input wire logic o_power_down,
  input wire logic [sdc_pkg::BANKS-1:0] o_bank_open,
  input wire logic o_burst_active
);
  // ==========================================================
  // Helpers: an edge counts only with clock enable now and before
  logic cke_q;
  wire logic taken;
  wire logic col;
  wire logic [2:0] cmd;
  wire logic [1:0] bidx;
  assign cmd = {i_row_strobe_n, i_col_strobe_n, i_write_en_n};
  assign bidx = {i_bank_select_low, i_bank_select_high};
  assign taken = i_cke && cke_q && !o_power_down;
  assign col = taken && (cmd[2:1] == 2'h2) && o_bank_open[bidx];
  // Previous clock enable, cleared by reset like the core's own
  always_ff @(posedge i_clk) begin
    cke_q <= i_srst ? 1'b0 : i_cke;
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // ==========================================================
  // Assertions
  a_act_opens: assert property (taken && cmd == 3'h3 |=> o_bank_open[$past(bidx)])
    else $error("activate left bank closed");
  a_pre_all: assert property (taken && cmd == 3'h2 && i_addr[10] |=> o_bank_open == 4'h0)
    else $error("all-bank close missed");
  a_stop_keeps: assert property (taken && cmd == 3'h6 |=>
    !o_burst_active && o_bank_open == $past(o_bank_open)) else $error("stop broke state");
  a_bl_one: assert property (col && i_burst_length_field == 3'h0 |=> !o_burst_active)
    else $error("single beat ran on");
  a_bl_four: assert property (col && i_burst_length_field == 3'h2 ##1
    (taken && cmd == 3'h7) [*3] |=> !o_burst_active) else $error("four beat count off");
  a_full_runs: assert property (col && i_burst_length_field == 3'h7 |=> o_burst_active)
    else $error("page burst ended");
  a_mask_off: assert property (taken && i_mask |-> ##2 !o_dq_oe)
    else $error("masked read still driven");
  a_pd_enter: assert property (!i_cke && o_bank_open == 4'h0 && !o_burst_active
    && !o_power_down |=> o_power_down) else $error("no power down");
  a_pd_exit: assert property (o_power_down && i_cke |=> !o_power_down)
    else $error("no power down exit");
  // Main scenarios reached
  c_pd: cover property (o_power_down ##1 !o_power_down);
  c_full: cover property (col && i_burst_length_field == 3'h7);
  c_mask: cover property (taken && i_mask ##1 o_dq_oe);
endmodule

bind sdc_sdram_core sdc_sdram_props props_i (
  .i_clk(i_clk), .i_srst(i_srst), .i_cke(i_cke), .i_row_strobe_n(i_row_strobe_n),
  .i_col_strobe_n(i_col_strobe_n), .i_write_en_n(i_write_en_n), .i_addr(i_addr),
  .i_bank_select_low(i_bank_select_low), .i_bank_select_high(i_bank_select_high),
  .i_mask(i_mask), .i_burst_length_field(i_burst_length_field), .o_dq_oe(o_dq_oe),
  .o_power_down(o_power_down), .o_bank_open(o_bank_open), .o_burst_active(o_burst_active)
);
`default_nettype wire

// *** testbench/sdc_ctrl_model.sv ***
// Controller model: drives DRAM command, mask and write data pins
`timescale 1ns/1ns
`default_nettype none

module sdc_ctrl_model (
  // Clock
  input wire logic i_clk,
  // Pins towards the DRAM
  output logic o_cke,
  output logic [2:0] o_cmd_n,
  output logic [sdc_pkg::ADDR_W-1:0] o_addr,
  output logic [sdc_pkg::BANK_W-1:0] o_bank,
  output logic o_mask,
  output logic [7:0] o_dq
);
  // ==========================================================
  // Pin driving, one command per clock just after the edge
  initial begin
    o_cke = 1'b1;
    o_cmd_n = 3'h7;
    o_addr = '0;
    o_bank = '0;
    o_mask = 1'b0;
    o_dq = 8'h00;
  end

  // Command, address, data and mask pins change only here, then hold across the sampling edge
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
      input logic [7:0] d, input logic m);
    o_cmd_n = c;
    o_bank = b;
    o_addr = a;
    o_dq = d;
    o_mask = m;
    @(posedge i_clk);
    #1;
  endtask

  // Idle; data lines churn so a stale word never looks valid
  task automatic idle(input int n);
    repeat (n) cmd(3'h7, 2'h0, 13'h0000, 8'($urandom), 1'b0);
  endtask

  // Rows are closed long before the active-time limit
  task automatic act(input logic [1:0] b, input logic [12:0] row);
    cmd(3'h3, b, row, 8'($urandom), 1'b0);
    idle(1); // Row-to-column gap
  endtask

  // Low only a few clocks, far inside the refresh period
  task automatic set_cke(input logic v);
    o_cke = v;
  endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the DRAM command block
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
  // ==========================================================
  // Pins, mode settings and scoreboard
  localparam logic [2:0] RD = 3'h5;
  localparam logic [2:0] WR = 3'h4;
  localparam logic [2:0] PRE = 3'h2;
  localparam logic [2:0] STOP = 3'h6;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cke, mask, oe, pd, wready, bt_r, bact;
  logic [2:0] cmd_n, bl_f, cl_r;
  logic [12:0] addr;
  logic [1:0] bank;
  logic [7:0] dqw, dqr, got;
  logic [3:0] open;
  logic [7:0] mem [4][64];
  logic [7:0] exp_q [$];
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int len = 1;

  initial begin
    bl_f = 3'h0;
    bt_r = 1'b0;
    cl_r = 3'h2;
    forever #50 clk = ~clk;
  end

  sdc_ctrl_model ctrl_i (.i_clk(clk), .o_cke(cke), .o_cmd_n(cmd_n), .o_addr(addr),
    .o_bank(bank), .o_mask(mask), .o_dq(dqw));

  sdc_sdram_core sdc_sdram_core_i (
    .i_clk(clk), .i_srst(srst), .i_cke(cke), .i_row_strobe_n(cmd_n[2]),
    .i_col_strobe_n(cmd_n[1]), .i_write_en_n(cmd_n[0]), .i_addr(addr),
    .i_bank_select_low(bank[1]), .i_bank_select_high(bank[0]), .i_mask(mask),
    .i_dq(dqw), .o_dq(dqr), .o_dq_oe(oe), .i_burst_length_field(bl_f),
    .i_burst_type(bt_r), .i_cas_latency(cl_r), .o_power_down(pd),
    .o_bank_open(open), .o_burst_active(bact), .o_write_ready(wready));

  // Read words checked in order; a word with nothing expected always fails
  always @(posedge clk) begin
    if (oe === 1'b1) begin
      if (exp_q.size() > 0) begin
        got = exp_q.pop_front();
        `CHK(dqr, got)
      end else begin
        `CHK(oe, 1'b0)
      end
    end
  end

  // Hang guard, well above the roughly 700 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  // ==========================================================
  // Tasks
  task automatic final_report();
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic mode(input logic [2:0] f, input logic t, input logic [2:0] c);
    bl_f = f;
    bt_r = t;
    cl_r = c;
    len = (f == sdc_pkg::BL_FULL) ? 64 : (f < 3'h4) ? (1 << f) : 1;
  endtask

  // Column of beat k; page bursts are always sequential
  function automatic int bcol(input int s, input int k);
    int m;
    m = len - 1;
    return (s & ~m) | (((bt_r && len < 64) ? (s ^ k) : (s + k)) & m);
  endfunction

  // n beats, beat mb masked, then a stop with fresh data on the pins
  task automatic wr(input logic [1:0] b, input int c, input int n, input int mb);
    logic [7:0] d;
    ctrl_i.idle(4); // Bus turned round before writing
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      if (k != mb) mem[b][bcol(c, k)] = d;
      ctrl_i.cmd(k == 0 ? WR : 3'h7, b, 13'(c), d, k == mb);
    end
    ctrl_i.cmd(STOP, b, 13'h0000, 8'($urandom), 1'b0);
    ctrl_i.idle(2 * n + 4);
  endtask

  // Read expecting n beats before the next command
  task automatic rd(input logic [1:0] b, input int c, input int n);
    for (int k = 0; k < n; k++) exp_q.push_back(mem[b][bcol(c, k)]);
    ctrl_i.cmd(RD, b, 13'(c), 8'($urandom), 1'b0);
    ctrl_i.idle(n - 1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(9));
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    ctrl_i.idle(2);
    `CHK(open, sdc_pkg::BANKS_CLOSED)
    `CHK(wready, 1'b1)
    mode(sdc_pkg::BL_FULL, 1'b1, 3'h3);
    for (int b = 1; b < 3; b++) begin
      ctrl_i.act(2'(b), 13'(b));
      wr(2'(b), 0, 64, 99);
    end
    ctrl_i.act(2'h0, 13'h0003);
    ctrl_i.act(2'h3, 13'h0005);
    `CHK(open, 4'hf)
    mode(sdc_pkg::BL_EIGHT, 1'b0, 3'h2);
    wr(2'h2, 8, 5, 2);
    for (int c = 1; c < 4; c++) begin
      mode(sdc_pkg::BL_EIGHT, 1'b1, 3'(c));
      rd(2'h1, 2, 8);
      rd(2'h2, 8, 8);
      rd(2'h1, 13, 3);
      rd(2'h2, 9, 8);
      ctrl_i.idle(8);
    end
    // Every defined length code; the page burst runs past its end
    foreach (codes[i]) begin
      mode(codes[i], codes[i][0], 3'h2);
      rd(2'h1, 5, len + 6 * (len / 64));
      `CHK(bact, len == 64)
      ctrl_i.cmd(STOP, 2'h1, 13'h0000, 8'($urandom), 1'b0);
      ctrl_i.idle(4);
    end
    mode(sdc_pkg::BL_EIGHT, 1'b0, 3'h2);
    for (int i = 0; i < 2; i++) begin
      rd(2'h1, 4, 2);
      ctrl_i.cmd(i ? PRE : STOP, 2'h1, 13'h0000, 8'($urandom), 1'b0);
      ctrl_i.idle(4);
      `CHK(open[1], i == 0)
      `CHK(bact, 1'b0)
    end
    // Read to the closed bank must stay silent
    ctrl_i.cmd(RD, 2'h1, 13'h0000, 8'($urandom), 1'b0);
    ctrl_i.idle(6);
    // Mask on the second beat hides that word only
    mode(sdc_pkg::BL_FOUR, 1'b0, 3'h2);
    exp_q.push_back(mem[2][8]);
    exp_q.push_back(mem[2][10]);
    exp_q.push_back(mem[2][11]);
    ctrl_i.cmd(RD, 2'h2, 13'h0008, 8'($urandom), 1'b0);
    ctrl_i.cmd(3'h7, 2'h2, 13'h0000, 8'($urandom), 1'b1);
    ctrl_i.idle(6);
    // Close all, nap with an activate that must be ignored
    ctrl_i.cmd(PRE, 2'h0, 13'h0400, 8'($urandom), 1'b0);
    ctrl_i.idle(1);
    `CHK(open, 4'h0)
    ctrl_i.set_cke(1'b0);
    ctrl_i.idle(1);
    `CHK(pd, 1'b1)
    ctrl_i.act(2'h1, 13'h0000);
    ctrl_i.set_cke(1'b1);
    ctrl_i.idle(1);
    `CHK(pd, 1'b0)
    `CHK(open, 4'h0)
    ctrl_i.act(2'h3, 13'h0000);
    ctrl_i.set_cke(1'b0);
    ctrl_i.idle(2);
    `CHK(pd, 1'b0)
    `CHK(open, 4'h8)
    ctrl_i.set_cke(1'b1);
    ctrl_i.idle(1);
    `CHK(exp_q.size(), 0)
    final_report();
  end
endmodule
`default_nettype wire
